// ===== pmop_pkg.sv
package pmop_pkg;
	localparam logic [7:0] CMD_CONV_CTRL = 8'h01;
	localparam logic [7:0] CONV_CTRL_RESET = 8'h00;
	localparam int ON_BIT = 7;
	localparam int SOFT_BIT = 6;
	localparam int MARGIN_HI = 5;
	localparam int MARGIN_LO = 2;
	localparam logic [7:0] WRITABLE_MASK = 8'hFC;
	localparam logic [3:0] MARGIN_OFF0 = 4'h0;
	localparam logic [3:0] MARGIN_OFF1 = 4'h1;
	localparam logic [3:0] MARGIN_OFF2 = 4'h2;
	localparam logic [3:0] MARGIN_LOW_IGN = 4'h5;
	localparam logic [3:0] MARGIN_LOW_ACT = 4'h6;
	localparam logic [3:0] MARGIN_HIGH_IGN = 4'h9;
	localparam logic [3:0] MARGIN_HIGH_ACT = 4'hA;
	localparam int BLOCK_BYTES = 6;
	localparam logic [2:0] BYTE_IDX_MAX = 3'h5;
	typedef enum logic [1:0] {
		PMOP_TGT_NOMINAL = 2'b00,
		PMOP_TGT_LOW = 2'b01,
		PMOP_TGT_HIGH = 2'b10
	} pmop_target_t;
	typedef enum logic [1:0] {
		PMOP_ST_OFF = 2'b00,
		PMOP_ST_RUN = 2'b01,
		PMOP_ST_DELAY = 2'b10,
		PMOP_ST_RAMP = 2'b11
	} pmop_state_t;
endpackage : pmop_pkg

// ===== pmop_blk_if.sv
interface pmop_blk_if;
	logic clear;
	logic byte_valid;
	logic [7:0] byte_data;
	logic [8*pmop_pkg::BLOCK_BYTES-1:0] value;
	logic [2:0] count;
	modport asm_side (input clear, input byte_valid, input byte_data, output value, output count);
	modport user_side (output clear, output byte_valid, output byte_data, input value, input count);
endinterface : pmop_blk_if

// ===== pmop_block_asm.sv
module pmop_block_asm (
	input wire logic clk_i,
	input wire logic reset_n_i,
	pmop_blk_if.asm_side blk
);
	logic [8*pmop_pkg::BLOCK_BYTES-1:0] value_reg, value_next;
	logic [2:0] count_reg, count_next;

	always_comb begin
		value_next = value_reg;
		count_next = count_reg;
		if (blk.clear) begin
			value_next = '0;
			count_next = 3'h0;
		end else if (blk.byte_valid && count_reg <= pmop_pkg::BYTE_IDX_MAX) begin
			// First byte lands in bits 7:0, each later one eight bits higher
			value_next[count_reg*8 +: 8] = blk.byte_data;
			count_next = count_reg + 3'h1;
		end
	end

	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			value_reg <= '0;
			count_reg <= 3'h0;
		end else begin
			value_reg <= value_next;
			count_reg <= count_next;
		end
	end

	assign blk.value = value_reg;
	assign blk.count = count_reg;

	a_first_byte_low: assert property (@(posedge clk_i) disable iff (!reset_n_i)
		(!blk.clear && blk.byte_valid && count_reg == 3'h0)
		|=> value_reg[7:0] == $past(blk.byte_data))
		else $error("first block byte not in bits 7:0");
	a_second_byte_next: assert property (@(posedge clk_i) disable iff (!reset_n_i)
		(!blk.clear && blk.byte_valid && count_reg == 3'h1)
		|=> value_reg[15:8] == $past(blk.byte_data) && count_reg == 3'h2)
		else $error("second block byte not in bits 15:8");
endmodule : pmop_block_asm

// ===== pmop_conv_ctrl.sv
module pmop_conv_ctrl (
	input wire logic clk_i,
	input wire logic reset_n_i,
	input wire logic cmd_wr_i,
	input wire logic cmd_rd_i,
	input wire logic [7:0] cmd_code_i,
	input wire logic [7:0] wr_data_i,
	output logic [7:0] rd_data_o,
	output logic rd_valid_o,
	output logic cmd_hit_o,
	input wire logic blk_clear_i,
	input wire logic blk_byte_valid_i,
	input wire logic [7:0] blk_byte_i,
	output logic [8*pmop_pkg::BLOCK_BYTES-1:0] blk_value_o,
	output logic [2:0] blk_count_o,
	input wire logic respect_cmd_i,
	input wire logic start_ok_i,
	input wire logic toff_delay_done_i,
	input wire logic vout_zero_i,
	input wire logic ov_uv_detect_i,
	output logic conv_enable_o,
	output logic power_stage_hiz_o,
	output logic soft_stop_o,
	output logic delay_run_o,
	output logic [1:0] margin_target_o,
	output logic fault_mask_o,
	output logic fault_event_o,
	output logic invalid_data_o
);
	logic [7:0] ctrl_reg, ctrl_next;
	logic [7:0] rd_data_reg, rd_data_next;
	logic rd_valid_reg, rd_valid_next;
	logic invalid_reg, invalid_next;
	pmop_pkg::pmop_state_t state_reg, state_next;
	logic [1:0] target_reg, target_next;
	logic mask_reg, mask_next;
	logic fault_reg, fault_next;
	logic hit;
	logic on_req;
	pmop_blk_if blk ();

	function automatic logic code_ok(input logic [3:0] m);
		unique case (m)
			pmop_pkg::MARGIN_OFF0, pmop_pkg::MARGIN_OFF1, pmop_pkg::MARGIN_OFF2,
			pmop_pkg::MARGIN_LOW_IGN, pmop_pkg::MARGIN_LOW_ACT,
			pmop_pkg::MARGIN_HIGH_IGN, pmop_pkg::MARGIN_HIGH_ACT: code_ok = 1'b1;
			default: code_ok = 1'b0;
		endcase
	endfunction : code_ok

	function automatic logic [3:0] margin_of(input logic [7:0] v);
		margin_of = v[pmop_pkg::MARGIN_HI:pmop_pkg::MARGIN_LO];
	endfunction : margin_of

	assign blk.clear = blk_clear_i;
	assign blk.byte_valid = blk_byte_valid_i;
	assign blk.byte_data = blk_byte_i;
	assign blk_value_o = blk.value;
	assign blk_count_o = blk.count;

	pmop_block_asm u_asm (
		.clk_i(clk_i),
		.reset_n_i(reset_n_i),
		.blk(blk.asm_side)
	);

	assign hit = (cmd_code_i == pmop_pkg::CMD_CONV_CTRL);
	assign cmd_hit_o = hit;

	// Register write and read-back; bad codes flag status and are dropped
	always_comb begin
		ctrl_next = ctrl_reg;
		invalid_next = invalid_reg;
		rd_valid_next = 1'b0;
		rd_data_next = rd_data_reg;
		if (cmd_wr_i && hit) begin
			if (code_ok(margin_of(wr_data_i))) begin
				ctrl_next = wr_data_i & pmop_pkg::WRITABLE_MASK;
			end else begin
				invalid_next = 1'b1;
			end
		end
		if (cmd_rd_i && hit) begin
			rd_data_next = ctrl_reg & pmop_pkg::WRITABLE_MASK;
			rd_valid_next = 1'b1;
		end
	end

	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			ctrl_reg <= pmop_pkg::CONV_CTRL_RESET;
			invalid_reg <= 1'b0;
			rd_valid_reg <= 1'b0;
			rd_data_reg <= 8'h00;
		end else begin
			ctrl_reg <= ctrl_next;
			invalid_reg <= invalid_next;
			rd_valid_reg <= rd_valid_next;
			rd_data_reg <= rd_data_next;
		end
	end

	// Command-respect gate: with it clear the on bit has no say in the sequencer
	assign on_req = ctrl_reg[pmop_pkg::ON_BIT] && respect_cmd_i;

	// Conversion sequencer
	always_comb begin
		state_next = state_reg;
		unique case (state_reg)
			pmop_pkg::PMOP_ST_OFF: begin
				if (on_req && start_ok_i) begin
					state_next = pmop_pkg::PMOP_ST_RUN;
				end
			end
			pmop_pkg::PMOP_ST_RUN: begin
				if (!on_req) begin
					if (ctrl_reg[pmop_pkg::SOFT_BIT]) begin
						state_next = pmop_pkg::PMOP_ST_DELAY;
					end else begin
						state_next = pmop_pkg::PMOP_ST_OFF;
					end
				end
			end
			pmop_pkg::PMOP_ST_DELAY: begin
				if (toff_delay_done_i) begin
					state_next = pmop_pkg::PMOP_ST_RAMP;
				end
			end
			pmop_pkg::PMOP_ST_RAMP: begin
				if (vout_zero_i) begin
					state_next = pmop_pkg::PMOP_ST_OFF;
				end
			end
		endcase
	end

	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			state_reg <= pmop_pkg::PMOP_ST_OFF;
		end else begin
			state_reg <= state_next;
		end
	end

	// Margin target and fault masking; fault event suppressed while masked
	always_comb begin
		target_next = pmop_pkg::PMOP_TGT_NOMINAL;
		mask_next = 1'b0;
		unique case (margin_of(ctrl_reg))
			pmop_pkg::MARGIN_LOW_IGN: begin
				target_next = pmop_pkg::PMOP_TGT_LOW;
				mask_next = ctrl_reg[pmop_pkg::ON_BIT];
			end
			pmop_pkg::MARGIN_LOW_ACT: begin
				target_next = pmop_pkg::PMOP_TGT_LOW;
			end
			pmop_pkg::MARGIN_HIGH_IGN: begin
				target_next = pmop_pkg::PMOP_TGT_HIGH;
				mask_next = ctrl_reg[pmop_pkg::ON_BIT];
			end
			pmop_pkg::MARGIN_HIGH_ACT: begin
				target_next = pmop_pkg::PMOP_TGT_HIGH;
			end
			default: begin
				target_next = pmop_pkg::PMOP_TGT_NOMINAL;
			end
		endcase
		fault_next = ov_uv_detect_i && !mask_next;
	end

	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			target_reg <= pmop_pkg::PMOP_TGT_NOMINAL;
			mask_reg <= 1'b0;
			fault_reg <= 1'b0;
		end else begin
			target_reg <= target_next;
			mask_reg <= mask_next;
			fault_reg <= fault_next;
		end
	end

	assign rd_data_o = rd_data_reg;
	assign rd_valid_o = rd_valid_reg;
	assign invalid_data_o = invalid_reg;
	assign conv_enable_o = (state_reg != pmop_pkg::PMOP_ST_OFF);
	assign power_stage_hiz_o = (state_reg == pmop_pkg::PMOP_ST_OFF);
	assign delay_run_o = (state_reg == pmop_pkg::PMOP_ST_DELAY);
	assign soft_stop_o = (state_reg == pmop_pkg::PMOP_ST_RAMP);
	assign margin_target_o = target_reg;
	assign fault_mask_o = mask_reg;
	assign fault_event_o = fault_reg;

	sequence s_soft_off_req;
		state_reg == pmop_pkg::PMOP_ST_RUN && !on_req && ctrl_reg[pmop_pkg::SOFT_BIT];
	endsequence
	sequence s_in_delay;
		state_reg == pmop_pkg::PMOP_ST_DELAY;
	endsequence

	a_no_start_early: assert property (@(posedge clk_i) disable iff (!reset_n_i)
		(state_reg == pmop_pkg::PMOP_ST_OFF && !(on_req && start_ok_i))
		|=> state_reg == pmop_pkg::PMOP_ST_OFF)
		else $error("conversion started without all conditions");
	a_hard_off: assert property (@(posedge clk_i) disable iff (!reset_n_i)
		(state_reg == pmop_pkg::PMOP_ST_RUN && !on_req && !ctrl_reg[pmop_pkg::SOFT_BIT])
		|=> power_stage_hiz_o && !conv_enable_o)
		else $error("immediate off did not float the stage");
	a_soft_off_seq: assert property (@(posedge clk_i) disable iff (!reset_n_i)
		s_soft_off_req |=> s_in_delay ##0 conv_enable_o)
		else $error("soft off skipped the delay");
	a_ramp_end: assert property (@(posedge clk_i) disable iff (!reset_n_i)
		(soft_stop_o && vout_zero_i) |=> power_stage_hiz_o)
		else $error("ramp did not stop at zero");
	a_respect_gate: assert property (@(posedge clk_i) disable iff (!reset_n_i)
		(!respect_cmd_i && state_reg == pmop_pkg::PMOP_ST_OFF)
		|=> state_reg == pmop_pkg::PMOP_ST_OFF)
		else $error("on bit honoured while ignored");
	a_bad_write_kept: assert property (@(posedge clk_i) disable iff (!reset_n_i)
		(cmd_wr_i && hit && !code_ok(margin_of(wr_data_i)))
		|=> ctrl_reg == $past(ctrl_reg) && invalid_data_o)
		else $error("invalid write changed the register");
	a_low_bits_zero: assert property (@(posedge clk_i) disable iff (!reset_n_i)
		rd_valid_o |-> rd_data_o[1:0] == 2'b00 && ctrl_reg[1:0] == 2'b00)
		else $error("read-only bits not zero");
	a_masked_fault: assert property (@(posedge clk_i) disable iff (!reset_n_i)
		(mask_next && ov_uv_detect_i) |=> !fault_event_o)
		else $error("fault reported while masked");
	a_act_fault: assert property (@(posedge clk_i) disable iff (!reset_n_i)
		(margin_of(ctrl_reg) == pmop_pkg::MARGIN_LOW_ACT && ov_uv_detect_i)
		|=> fault_event_o && margin_target_o == pmop_pkg::PMOP_TGT_LOW)
		else $error("act-on-fault low margin wrong");
	a_high_target: assert property (@(posedge clk_i) disable iff (!reset_n_i)
		(margin_of(ctrl_reg) == pmop_pkg::MARGIN_HIGH_ACT)
		|=> margin_target_o == pmop_pkg::PMOP_TGT_HIGH)
		else $error("high margin target wrong");
endmodule : pmop_conv_ctrl

// ===== pmop_host.sv
module pmop_host (
	input wire logic clk_i,
	output logic wr_o,
	output logic rd_o,
	output logic [7:0] code_o,
	output logic [7:0] data_o,
	output logic clr_o,
	output logic bv_o,
	output logic [7:0] b_o
);
	timeunit 1ns;
	timeprecision 1ns;
	initial begin
		wr_o = 1'b0;
		rd_o = 1'b0;
		code_o = 8'h00;
		data_o = 8'h00;
		clr_o = 1'b0;
		bv_o = 1'b0;
		b_o = 8'h00;
	end
	// Released data and byte lines show the inverse, the code line only after rd, so stale data is never mistaken for valid
	task automatic wr(input logic [7:0] c, input logic [7:0] d);
		@(posedge clk_i);
		wr_o <= 1'b1;
		code_o <= c;
		data_o <= d;
		@(posedge clk_i);
		wr_o <= 1'b0;
		data_o <= ~d;
	endtask : wr
	task automatic rd(input logic [7:0] c);
		@(posedge clk_i);
		rd_o <= 1'b1;
		code_o <= c;
		@(posedge clk_i);
		rd_o <= 1'b0;
		code_o <= ~c;
	endtask : rd
	// Bytes go out in ascending order, byte 0 first
	task automatic bs(input logic [7:0] d);
		@(posedge clk_i);
		bv_o <= 1'b1;
		b_o <= d;
		@(posedge clk_i);
		bv_o <= 1'b0;
		b_o <= ~d;
	endtask : bs
	task automatic clr();
		@(posedge clk_i);
		clr_o <= 1'b1;
		@(posedge clk_i);
		clr_o <= 1'b0;
	endtask : clr
endmodule : pmop_host

// ===== pmbus_operation_command_test.sv
module pmbus_operation_command_test;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk_i, reset_n_i, wr, rd, clr, bv, rsp, sok, dd, vz, ov;
	logic [7:0] code, wd, bb, rdd;
	logic [47:0] val;
	logic [2:0] cnt;
	logic [1:0] tgt;
	logic rv, en, hiz, ss, dr, msk, fe, inv, hit;
	int err_total = 0;
	int checks_done = 0;
	pmop_host h (.clk_i(clk_i), .wr_o(wr), .rd_o(rd), .code_o(code), .data_o(wd),
		.clr_o(clr), .bv_o(bv), .b_o(bb));
	pmop_conv_ctrl uut (.clk_i(clk_i), .reset_n_i(reset_n_i), .cmd_wr_i(wr), .cmd_rd_i(rd),
		.cmd_code_i(code), .wr_data_i(wd), .rd_data_o(rdd), .rd_valid_o(rv), .cmd_hit_o(hit),
		.blk_clear_i(clr), .blk_byte_valid_i(bv), .blk_byte_i(bb), .blk_value_o(val),
		.blk_count_o(cnt), .respect_cmd_i(rsp), .start_ok_i(sok), .toff_delay_done_i(dd),
		.vout_zero_i(vz), .ov_uv_detect_i(ov), .conv_enable_o(en), .power_stage_hiz_o(hiz),
		.soft_stop_o(ss), .delay_run_o(dr), .margin_target_o(tgt), .fault_mask_o(msk),
		.fault_event_o(fe), .invalid_data_o(inv));
	task automatic chk(input string n, input logic [47:0] e, input logic [47:0] g);
		checks_done++;
		if (g !== e) begin
			err_total++;
			$display("mismatch %s expected %h seen %h", n, e, g);
		end
	endtask : chk
	task automatic st(input int n);
		repeat (n) @(posedge clk_i);
		#1;
	endtask : st
	task automatic rdchk(input logic [7:0] e);
		h.rd(8'h01);
		#1;
		chk("rd_valid", 48'(1'b1), 48'(rv));
		chk("rd_data", 48'(e), 48'(rdd));
	endtask : rdchk
	task automatic t_reset();
		rdchk(8'h00);
		chk("hiz", 48'(1'b1), 48'(hiz));
		chk("enable", 48'(1'b0), 48'(en));
		chk("invalid", 48'(1'b0), 48'(inv));
	endtask : t_reset
	task automatic t_code();
		h.wr(8'h02, 8'h80);
		st(3);
		rdchk(8'h00);
		h.rd(8'h02);
		#1;
		chk("rd_valid", 48'(1'b0), 48'(rv));
		chk("cmd_hit", 48'(1'b0), 48'(hit));
		fork
			h.rd(8'h01);
			begin
				@(posedge clk_i);
				#1;
				chk("cmd_hit", 48'(1'b1), 48'(hit));
			end
		join
	endtask : t_code
	task automatic t_margin();
		logic [3:0] mc [7] = '{4'h0, 4'h1, 4'h2, 4'h5, 4'h6, 4'h9, 4'hA};
		logic [1:0] mt [7] = '{2'h0, 2'h0, 2'h0, 2'h1, 2'h1, 2'h2, 2'h2};
		logic mm [7] = '{1'b0, 1'b0, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0};
		@(posedge clk_i) ov <= 1'b1;
		for (int i = 0; i < 7; i++) begin
			h.wr(8'h01, {2'b10, mc[i], 2'b11});
			st(3);
			chk("target", 48'(mt[i]), 48'(tgt));
			chk("mask", 48'(mm[i]), 48'(msk));
			chk("fault_event", 48'(!mm[i]), 48'(fe));
			rdchk({2'b10, mc[i], 2'b00});
		end
		@(posedge clk_i) ov <= 1'b0;
		h.wr(8'h01, 8'h8C);
		st(2);
		chk("invalid", 48'(1'b1), 48'(inv));
		rdchk(8'hA8);
	endtask : t_margin
	task automatic t_stop();
		h.wr(8'h01, 8'h80);
		st(3);
		chk("enable", 48'(1'b1), 48'(en));
		chk("hiz", 48'(1'b0), 48'(hiz));
		h.wr(8'h01, 8'h00);
		st(2);
		chk("hiz", 48'(1'b1), 48'(hiz));
		h.wr(8'h01, 8'h80);
		h.wr(8'h01, 8'h40);
		st(5);
		chk("delay", 48'(2'b11), 48'({dr, en}));
		@(posedge clk_i) dd <= 1'b1;
		@(posedge clk_i) dd <= 1'b0;
		st(1);
		chk("soft_stop", 48'(2'b11), 48'({ss, en}));
		@(posedge clk_i) vz <= 1'b1;
		@(posedge clk_i) vz <= 1'b0;
		st(1);
		chk("hiz", 48'(2'b10), 48'({hiz, en}));
	endtask : t_stop
	task automatic t_gate();
		@(posedge clk_i) rsp <= 1'b0;
		h.wr(8'h01, 8'h80);
		st(3);
		chk("enable", 48'(1'b0), 48'(en));
		@(posedge clk_i) begin
			rsp <= 1'b1;
			sok <= 1'b0;
		end
		st(3);
		chk("enable", 48'(1'b0), 48'(en));
		@(posedge clk_i) sok <= 1'b1;
		st(3);
		chk("enable", 48'(1'b1), 48'(en));
	endtask : t_gate
	task automatic t_block();
		h.clr();
		for (int i = 1; i < 8; i++) h.bs(8'(8'h11 * i));
		st(1);
		chk("blk_value", 48'h665544332211, val);
		chk("blk_count", 48'(3'h6), 48'(cnt));
	endtask : t_block
	task automatic results();
		$display("errors %0d checks %0d", err_total, checks_done);
		if (err_total == 0 && checks_done > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask : results
	initial begin
		clk_i = 1'b0;
		forever #25 clk_i = ~clk_i;
	end
	initial begin
		#1000000;
		err_total++;
		results();
	end
	initial begin
		reset_n_i = 1'b0;
		{rsp, sok, dd, vz, ov} = 5'b11000;
		repeat (12) @(posedge clk_i);
		reset_n_i <= 1'b1;
		t_reset();
		t_code();
		t_margin();
		t_stop();
		t_gate();
		t_block();
		results();
	end
endmodule : pmbus_operation_command_test
